// ### logic/ppic_top.sv
// power-save, control and event interrupt logic of the transceiver
`timescale 1ns/1ps
module ppic_top #(
	parameter int NLP_CYCLES = ppic_pkg::NLP_CYCLES
) (
	input  wire logic                  i_clk,            // 50 MHz clock
	input  wire logic                  i_rst_b,          // async reset, active low
	input  wire ppic_pkg::ppic_bus_req_t i_bus,          // register port request
	output logic [ppic_pkg::DATA_W-1:0] o_rdata,         // read data, cycle after read
	input  wire logic                  i_std_powerdown,  // standard power-down active
	input  wire logic                  i_partner_detect, // energy detect saw partner
	input  wire logic                  i_link_up,        // link status
	input  wire ppic_pkg::ppic_chg_t   i_chg,            // status change pulses
	input  wire logic                  i_false_carrier,  // false carrier pulse
	input  wire logic                  i_rx_error,       // receive error pulse
	input  wire logic                  i_full_duplex,    // duplex status
	input  wire logic                  i_collision,      // raw collision detect
	input  wire logic                  i_pin_in,         // shared pin level
	output logic                       o_pin_out,        // shared pin drive level
	output logic                       o_pin_oe,         // shared pin drive enable
	output logic                       o_powerdown_req,  // pin asks for power-down
	output logic                       o_clk_disable,    // stop internal clocks
	output logic                       o_active_sleep,   // circuitry powered down
	output logic                       o_nlp_pulse,      // send one link pulse
	output logic                       o_scr_bypass,     // bypass tx scrambler
	output logic [3:0]                 o_fifo_nibbles,   // loopback fifo depth
	output logic                       o_col,            // collision indication
	output logic                       o_irq_active,     // interrupt asserted
	output logic                       o_irq_pending     // enabled event pending
);
	localparam int NLP_W = $clog2(NLP_CYCLES + 1);

	generate
		if (NLP_CYCLES < 2) begin : g_bad_nlp
			$error("NLP_CYCLES must be at least 2");
		end
	endgenerate

	function automatic logic [3:0] depth_nibbles(input logic [1:0] code);
		case (code)
			2'h0:    depth_nibbles = ppic_pkg::FIFO_NIB_0;
			2'h1:    depth_nibbles = ppic_pkg::FIFO_NIB_1;
			2'h2:    depth_nibbles = ppic_pkg::FIFO_NIB_2;
			default: depth_nibbles = ppic_pkg::FIFO_NIB_3;
		endcase
	endfunction

	// clear and a new event in one cycle leave a count of one
	function automatic logic [7:0] cnt_next(input logic [7:0] cnt, input logic inc, input logic clr);
		if (clr) begin
			cnt_next = inc ? ppic_pkg::CNT_ONE : ppic_pkg::CNT_ZERO;
		end else if (inc && cnt != ppic_pkg::CNT_MAX) begin
			cnt_next = cnt + ppic_pkg::CNT_ONE;
		end else begin
			cnt_next = cnt;
		end
	endfunction

	function automatic logic crossed_half(input logic [7:0] old_cnt, input logic [7:0] new_cnt);
		crossed_half = (old_cnt <= ppic_pkg::CNT_HALF) && (new_cnt > ppic_pkg::CNT_HALF);
	endfunction

	function automatic logic hit(input ppic_pkg::ppic_bus_req_t b, input logic [4:0] a, input logic rd);
		hit = (rd ? b.rd : b.wr) && (b.addr == a);
	endfunction

	ppic_pkg::ppic_ctrl_t   ctrl_r;
	ppic_pkg::ppic_ctrl_t   ctrl_nxt;
	ppic_pkg::ppic_events_t flags_r;
	ppic_pkg::ppic_events_t flags_set;
	ppic_pkg::ppic_events_t flags_nxt;
	logic [7:0]             en_r;
	logic [7:0]             fc_cnt_r;
	logic [7:0]             fc_cnt_nxt;
	logic [7:0]             re_cnt_r;
	logic [7:0]             re_cnt_nxt;
	ppic_pkg::ppic_pstate_t ps_r;
	ppic_pkg::ppic_pstate_t ps_nxt;
	logic [NLP_W-1:0]       nlp_cnt_r;
	logic                   pin_meta_r;
	logic                   pin_sync_r;
	logic                   sleep_sel;
	logic                   irq_req;
	logic                   pend_any;
	logic [15:0]            rdata_nxt;

	// control register write; reserved bits stay zero
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (hit(i_bus, ppic_pkg::ADDR_SPEC_CTRL, 1'b0)) begin
			ctrl_nxt = ppic_pkg::ppic_ctrl_t'(i_bus.wdata);
			ctrl_nxt.rsvd = 3'h0;
			// a set outside power-down is dropped unless the bit is already set, a clear always taken
			if (!i_std_powerdown && !ctrl_r.clk_disable) begin
				ctrl_nxt.clk_disable = 1'b0;
			end
			// reserved mode code leaves the old mode in force
			if (ctrl_nxt.psave_mode == ppic_pkg::PSM_RESERVED) begin
				ctrl_nxt.psave_mode = ctrl_r.psave_mode;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctrl_r <= ppic_pkg::ppic_ctrl_t'(ppic_pkg::CTRL_RESET);
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// event enables in the low byte of the event register
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			en_r <= ppic_pkg::EVENT_EN_RESET;
		end else if (hit(i_bus, ppic_pkg::ADDR_EVENT, 1'b0)) begin
			en_r <= i_bus.wdata[7:0];
		end
	end

	// saturating event counters, cleared by their own read
	always_comb begin
		fc_cnt_nxt = cnt_next(fc_cnt_r, i_false_carrier, hit(i_bus, ppic_pkg::ADDR_FC_CNT, 1'b1));
		re_cnt_nxt = cnt_next(re_cnt_r, i_rx_error, hit(i_bus, ppic_pkg::ADDR_RE_CNT, 1'b1));
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			fc_cnt_r <= ppic_pkg::CNT_ZERO;
			re_cnt_r <= ppic_pkg::CNT_ZERO;
		end else begin
			fc_cnt_r <= fc_cnt_nxt;
			re_cnt_r <= re_cnt_nxt;
		end
	end

	// sticky flags; a new event in the clearing read survives it
	always_comb begin
		flags_set.link_quality = i_chg.link_quality && i_link_up;
		flags_set.energy       = i_chg.energy;
		flags_set.link_status  = i_chg.link_status;
		flags_set.speed        = i_chg.speed;
		flags_set.duplex       = i_chg.duplex;
		flags_set.an_done      = i_chg.an_done;
		flags_set.fc_half      = crossed_half(fc_cnt_r, fc_cnt_nxt);
		flags_set.re_half      = crossed_half(re_cnt_r, re_cnt_nxt);
		if (hit(i_bus, ppic_pkg::ADDR_EVENT, 1'b1)) begin
			flags_nxt = flags_set;
		end else begin
			flags_nxt = flags_r | flags_set;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			flags_r <= ppic_pkg::ppic_events_t'(ppic_pkg::EVENT_FL_RESET);
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// interrupt request from enabled events or the test bit
	always_comb begin
		pend_any = |(flags_r & en_r);
		irq_req  = (ctrl_r.irq_en && pend_any) || ctrl_r.irq_test;
	end

	// power-save state
	always_comb begin
		sleep_sel = ctrl_r.psave_en && (ctrl_r.psave_mode == ppic_pkg::PSM_ACT_SLEEP);
		ps_nxt    = ps_r;
		case (ps_r)
			ppic_pkg::PS_FULL: begin
				if (sleep_sel) begin
					ps_nxt = ppic_pkg::PS_SLEEP;
				end
			end
			ppic_pkg::PS_SLEEP: begin
				if (!sleep_sel) begin
					ps_nxt = ppic_pkg::PS_FULL;
				end else if (i_partner_detect) begin
					ps_nxt = ppic_pkg::PS_WOKEN;
				end
			end
			ppic_pkg::PS_WOKEN: begin
				// stays awake until software leaves and re-enters sleep
				if (!sleep_sel) begin
					ps_nxt = ppic_pkg::PS_FULL;
				end
			end
			default: begin
				ps_nxt = ppic_pkg::PS_FULL;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ps_r <= ppic_pkg::PS_FULL;
		end else begin
			ps_r <= ps_nxt;
		end
	end

	// link pulse timer, runs only while asleep
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			nlp_cnt_r   <= '0;
			o_nlp_pulse <= 1'b0;
		end else if (ps_r != ppic_pkg::PS_SLEEP) begin
			nlp_cnt_r   <= '0;
			o_nlp_pulse <= 1'b0;
		end else if (nlp_cnt_r == NLP_W'(NLP_CYCLES - 1)) begin
			nlp_cnt_r   <= '0;
			o_nlp_pulse <= 1'b1;
		end else begin
			nlp_cnt_r   <= nlp_cnt_r + NLP_W'(1);
			o_nlp_pulse <= 1'b0;
		end
	end

	// shared pin input comes from outside the clock domain
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pin_meta_r <= 1'b1;
			pin_sync_r <= 1'b1;
		end else begin
			pin_meta_r <= i_pin_in;
			pin_sync_r <= pin_meta_r;
		end
	end

	// registered outputs; one cycle behind their causes
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_clk_disable   <= 1'b0;
			o_active_sleep  <= 1'b0;
			o_scr_bypass    <= 1'b0;
			o_fifo_nibbles  <= ppic_pkg::FIFO_NIB_1;
			o_col           <= 1'b0;
			o_irq_active    <= 1'b0;
			o_irq_pending   <= 1'b0;
			o_pin_out       <= 1'b1;
			o_pin_oe        <= 1'b0;
			o_powerdown_req <= 1'b0;
		end else begin
			o_clk_disable   <= ctrl_r.clk_disable && i_std_powerdown;
			o_active_sleep  <= (ps_r == ppic_pkg::PS_SLEEP);
			o_scr_bypass    <= ctrl_r.scr_bypass;
			o_fifo_nibbles  <= depth_nibbles(ctrl_r.fifo_depth);
			o_col           <= i_collision && (!i_full_duplex || ctrl_r.col_fd_en);
			o_irq_active    <= irq_req;
			o_irq_pending   <= pend_any;
			o_pin_out       <= irq_req ^ ctrl_r.irq_pol;
			o_pin_oe        <= ctrl_r.irq_oe;
			// pin as power-down input is taken active low
			o_powerdown_req <= !ctrl_r.irq_oe && !pin_sync_r;
		end
	end

	// read mux; data stand only in the cycle after the strobe
	always_comb begin
		rdata_nxt = 16'h0000;
		if (i_bus.rd) begin
			case (i_bus.addr)
				ppic_pkg::ADDR_STATUS_SUM: rdata_nxt[ppic_pkg::STAT_PEND_BIT] = pend_any;
				ppic_pkg::ADDR_SPEC_CTRL:  rdata_nxt = ctrl_r;
				ppic_pkg::ADDR_EVENT:      rdata_nxt = {flags_r, en_r};
				ppic_pkg::ADDR_FC_CNT:     rdata_nxt = {8'h00, fc_cnt_r};
				ppic_pkg::ADDR_RE_CNT:     rdata_nxt = {8'h00, re_cnt_r};
				default:                   rdata_nxt = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rdata <= 16'h0000;
		end else begin
			o_rdata <= rdata_nxt;
		end
	end
endmodule

// ### logic/ppic_pkg.sv
// shared constants and types of the phy power and interrupt control block
package ppic_pkg;
	localparam int          ADDR_W          = 5;
	localparam int          DATA_W          = 16;
	localparam logic [4:0]  ADDR_STATUS_SUM = 5'h10;
	localparam logic [4:0]  ADDR_SPEC_CTRL  = 5'h11;
	localparam logic [4:0]  ADDR_EVENT      = 5'h12;
	localparam logic [4:0]  ADDR_FC_CNT     = 5'h14;
	localparam logic [4:0]  ADDR_RE_CNT     = 5'h15;
	localparam logic [15:0] CTRL_RESET      = 16'h0108;
	localparam logic [7:0]  EVENT_EN_RESET  = 8'h00;
	localparam logic [7:0]  EVENT_FL_RESET  = 8'h00;
	localparam int          STAT_PEND_BIT   = 7;
	localparam logic [1:0]  PSM_FULL        = 2'h0;
	localparam logic [1:0]  PSM_RESERVED    = 2'h1;
	localparam logic [1:0]  PSM_ACT_SLEEP   = 2'h2;
	localparam logic [7:0]  CNT_HALF        = 8'h7F;
	localparam logic [7:0]  CNT_MAX         = 8'hFF;
	localparam logic [7:0]  CNT_ONE         = 8'h01;
	localparam logic [7:0]  CNT_ZERO        = 8'h00;
	localparam logic [3:0]  FIFO_NIB_0      = 4'h4;
	localparam logic [3:0]  FIFO_NIB_1      = 4'h5;
	localparam logic [3:0]  FIFO_NIB_2      = 4'h6;
	localparam logic [3:0]  FIFO_NIB_3      = 4'h8;
	localparam int          CLK_HZ          = 50_000_000;
	localparam int          NLP_PERIOD_MS   = 1400;
	localparam int          NLP_CYCLES      = NLP_PERIOD_MS * (CLK_HZ / 1000);

	typedef struct packed {
		logic       clk_disable;
		logic       psave_en;
		logic [1:0] psave_mode;
		logic       scr_bypass;
		logic       spare;
		logic [1:0] fifo_depth;
		logic [2:0] rsvd;
		logic       col_fd_en;
		logic       irq_pol;
		logic       irq_test;
		logic       irq_en;
		logic       irq_oe;
	} ppic_ctrl_t;

	// bit 7 here is event register bit 15
	typedef struct packed {
		logic link_quality;
		logic energy;
		logic link_status;
		logic speed;
		logic duplex;
		logic an_done;
		logic fc_half;
		logic re_half;
	} ppic_events_t;

	typedef struct packed {
		logic link_quality;
		logic energy;
		logic link_status;
		logic speed;
		logic duplex;
		logic an_done;
	} ppic_chg_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} ppic_bus_req_t;

	typedef enum logic [2:0] {
		PS_FULL  = 3'b001,
		PS_SLEEP = 3'b010,
		PS_WOKEN = 3'b100
	} ppic_pstate_t;
endpackage

// ### verification/ppic_chk.sv
// port assertions of the power and interrupt control block
`timescale 1ns/1ps
module ppic_chk (
	input wire logic                    i_clk,           // clock
	input wire logic                    i_rst_b,         // reset, active low
	input wire ppic_pkg::ppic_bus_req_t i_bus,           // register port
	input wire logic [15:0]             o_rdata,         // read data
	input wire logic                    i_std_powerdown, // power-down level
	input wire logic                    i_full_duplex,   // duplex
	input wire logic                    i_collision,     // raw collision
	input wire logic                    o_pin_oe,        // pin enable
	input wire logic                    o_powerdown_req, // pin power-down
	input wire logic                    o_clk_disable,   // clocks off
	input wire logic                    o_nlp_pulse,     // link pulse
	input wire logic                    o_scr_bypass,    // scrambler bypass
	input wire logic [3:0]              o_fifo_nibbles,  // fifo depth
	input wire logic                    o_col,           // collision out
	input wire logic                    o_irq_active     // interrupt asserted
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	function automatic logic [3:0] nib_of(input logic [1:0] c);
		return (c == 2'h3) ? 4'h8 : {2'h0, c} + 4'h4;
	endfunction
	sequence ctrl_wr;
		i_bus.wr && i_bus.addr == ppic_pkg::ADDR_SPEC_CTRL;
	endsequence
	sequence test_wr;
		i_bus.wr && i_bus.addr == ppic_pkg::ADDR_SPEC_CTRL && i_bus.wdata[2];
	endsequence
	// derived outputs lag the control register by one cycle
	chk_oe_follow: assert property (ctrl_wr |-> ##2 o_pin_oe == $past(i_bus.wdata[0], 2))
		else $error("pin enable does not follow control write");
	chk_scr_follow: assert property (ctrl_wr |-> ##2 o_scr_bypass == $past(i_bus.wdata[11], 2))
		else $error("scrambler bypass does not follow control write");
	chk_fifo_map: assert property (ctrl_wr |-> ##2 o_fifo_nibbles == nib_of($past(i_bus.wdata[9:8], 2)))
		else $error("fifo depth does not match its code");
	chk_clk_gate: assert property (!i_std_powerdown |=> !o_clk_disable)
		else $error("clock disabled outside power-down");
	chk_col_half: assert property (i_collision && !i_full_duplex |=> o_col)
		else $error("half duplex collision not signalled");
	chk_col_quiet: assert property (!i_collision |=> !o_col)
		else $error("collision without cause");
	chk_nlp_single: assert property (o_nlp_pulse |=> !o_nlp_pulse)
		else $error("link pulse longer than one cycle");
	chk_pd_excl: assert property (o_powerdown_req |-> !o_pin_oe)
		else $error("power-down request while pin is an output");
	chk_rdata_idle: assert property (!i_bus.rd |=> o_rdata == 16'h0000)
		else $error("read data outside read answer cycle");
	// a later write may clear the test bit, so only the first answer is held
	chk_test_irq: assert property (test_wr |-> ##2 o_irq_active)
		else $error("test bit did not raise the interrupt");
endmodule

bind ppic_top ppic_chk i_ppic_chk (
	.i_clk(i_clk), .i_rst_b(i_rst_b), .i_bus(i_bus), .o_rdata(o_rdata),
	.i_std_powerdown(i_std_powerdown), .i_full_duplex(i_full_duplex),
	.i_collision(i_collision), .o_pin_oe(o_pin_oe), .o_powerdown_req(o_powerdown_req),
	.o_clk_disable(o_clk_disable), .o_nlp_pulse(o_nlp_pulse), .o_scr_bypass(o_scr_bypass),
	.o_fifo_nibbles(o_fifo_nibbles), .o_col(o_col), .o_irq_active(o_irq_active)
);

// ### verification/ppic_pin_model.sv
// shared interrupt or power-down pin with its board pull-up
`timescale 1ns/1ps
module ppic_pin_model (
	input  wire logic i_pin_out, // level driven by the block
	input  wire logic i_pin_oe,  // block drives the pin
	input  wire logic i_ext_low, // external switch pulls pin low
	output logic      o_pin      // resolved pin level
);
	// a released pin goes to the pull-up unless the external switch pulls it low, never to a stale value
	assign o_pin = i_pin_oe ? i_pin_out : !i_ext_low;
endmodule

// ### verification/ppic_top_tb.sv
// self-checking bench of the power and interrupt control block
`timescale 1ns/1ps
module ppic_top_tb;
	typedef struct packed {
		logic [4:0]  a;
		logic [15:0] d;
		logic [15:0] e;
		logic [3:0]  f;
	} ppic_row_t;
	localparam int NLP = 16;
	localparam ppic_row_t ROWS [8] = '{
		'{5'h11, 16'h0A10, 16'h0A10, 4'h6}, '{5'h11, 16'h10E8, 16'h0008, 4'h4},
		'{5'h11, 16'h8300, 16'h0300, 4'h8}, '{5'h12, 16'hFFA5, 16'h00A5, 4'h8},
		'{5'h14, 16'h00FF, 16'h0000, 4'h8}, '{5'h1F, 16'hFFFF, 16'h0000, 4'h8},
		'{5'h12, 16'h0000, 16'h0000, 4'h8}, '{5'h11, 16'h0108, 16'h0108, 4'h5}};
	logic                    i_clk   = 1'b0;
	logic                    i_rst_b = 1'b0;
	ppic_pkg::ppic_bus_req_t bus     = '0;
	ppic_pkg::ppic_chg_t     chg     = '0;
	logic                    pd = 1'b0, det = 1'b0, lnk = 1'b0, fc = 1'b0;
	logic                    fd = 1'b0, col = 1'b0, ext_low = 1'b0, re = 1'b0, scr;
	logic [15:0]             rdata;
	logic [3:0]              nib;
	logic                    pin, pin_out, pin_oe, pd_req, clk_dis, sleep, nlp, col_o, irq, pend;
	int                      err_total = 0, checks = 0, n;

	ppic_top #(.NLP_CYCLES(NLP)) i_ppic_top (
		.i_clk(i_clk), .i_rst_b(i_rst_b), .i_bus(bus), .o_rdata(rdata),
		.i_std_powerdown(pd), .i_partner_detect(det), .i_link_up(lnk), .i_chg(chg),
		.i_false_carrier(fc), .i_rx_error(re), .i_full_duplex(fd), .i_collision(col),
		.i_pin_in(pin), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_powerdown_req(pd_req),
		.o_clk_disable(clk_dis), .o_active_sleep(sleep), .o_nlp_pulse(nlp), .o_scr_bypass(scr),
		.o_fifo_nibbles(nib), .o_col(col_o), .o_irq_active(irq), .o_irq_pending(pend));
	ppic_pin_model i_ppic_pin_model (.i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_ext_low(ext_low), .o_pin(pin));

	always #10 i_clk = ~i_clk;

	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge i_clk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge i_clk) bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge i_clk) bus <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge i_clk) bus.rd <= 1'b0;
		#1 cmp(rdata, e);
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge i_clk);
		#1;
	endtask
	task automatic ev(input logic [5:0] c);
		@(posedge i_clk) chg <= c;
		@(posedge i_clk) chg <= '0;
	endtask
	// spaced pulses, one count each, since a held level counts every cycle; both=0 keeps rx errors quiet
	task automatic cnt(input int k, input logic both);
		repeat (k) begin
			@(posedge i_clk) begin
				fc <= 1'b1;
				re <= both;
			end
			@(posedge i_clk) begin
				fc <= 1'b0;
				re <= 1'b0;
			end
		end
	endtask
	task automatic end_of_test;
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		#1_000_000;
		err_total++;
		end_of_test();
	end

	initial begin
		repeat (20) @(posedge i_clk);
		i_rst_b <= 1'b1;
		tick(1);
		cmp(16'(pin), 16'h0001);
		cmp(16'(nib), 16'h0005);
		rd(5'h11, 16'h0108);
		rd(5'h12, 16'h0000);
		foreach (ROWS[i]) begin
			wr(ROWS[i].a, ROWS[i].d);
			rd(ROWS[i].a, ROWS[i].e);
			cmp(16'(nib), 16'(ROWS[i].f));
			if (ROWS[i].a == 5'h11) begin
				cmp(16'(scr), 16'(ROWS[i].e[11]));
			end
		end
		@(posedge i_clk) col <= 1'b1;
		tick(2);
		cmp(16'(col_o), 16'h0001);
		@(posedge i_clk) fd <= 1'b1;
		tick(2);
		cmp(16'(col_o), 16'h0000);
		wr(5'h11, 16'h0118);
		tick(2);
		cmp(16'(col_o), 16'h0001);
		@(posedge i_clk) col <= 1'b0;
		wr(5'h12, 16'h0020);
		wr(5'h11, 16'h010B);
		ev(6'h08);
		tick(3);
		cmp(16'(irq), 16'h0001);
		cmp(16'(pin), 16'h0000);
		rd(5'h12, 16'h2020);
		tick(2);
		cmp(16'(pin), 16'h0001);
		wr(5'h11, 16'h0109);
		ev(6'h08);
		tick(3);
		cmp(16'(irq), 16'h0000);
		cmp(16'(pend), 16'h0001);
		rd(5'h10, 16'h0080);
		rd(5'h12, 16'h2020);
		rd(5'h10, 16'h0000);
		wr(5'h11, 16'h0005);
		tick(2);
		cmp(16'(irq), 16'h0001);
		cmp(16'(pin), 16'h0001);
		wr(5'h11, 16'h0108);
		tick(2);
		cmp(16'(irq), 16'h0000);
		ev(6'h20);
		rd(5'h12, 16'h0020);
		@(posedge i_clk) lnk <= 1'b1;
		ev(6'h20);
		rd(5'h12, 16'h8020);
		cnt(127, 1'b1);
		rd(5'h12, 16'h0020);
		cnt(1, 1'b1);
		rd(5'h14, 16'h0080);
		rd(5'h15, 16'h0080);
		rd(5'h12, 16'h0320);
		cnt(300, 1'b0);
		rd(5'h14, 16'h00FF);
		rd(5'h14, 16'h0000);
		rd(5'h15, 16'h0000);
		rd(5'h12, 16'h0220);
		@(posedge i_clk) pd <= 1'b1;
		wr(5'h11, 16'h8108);
		rd(5'h11, 16'h8108);
		cmp(16'(clk_dis), 16'h0001);
		@(posedge i_clk) pd <= 1'b0;
		tick(2);
		cmp(16'(clk_dis), 16'h0000);
		wr(5'h11, 16'h2108);
		tick(4);
		cmp(16'(sleep), 16'h0000);
		wr(5'h11, 16'h6108);
		for (n = 0; n < 40 && nlp !== 1'b1; n++) tick(1);
		cmp(16'(nlp), 16'h0001);
		cmp(16'(sleep), 16'h0001);
		tick(1);
		for (n = 1; n < 40 && nlp !== 1'b1; n++) tick(1);
		cmp(16'(n), 16'(NLP));
		@(posedge i_clk) det <= 1'b1;
		@(posedge i_clk) det <= 1'b0;
		tick(3);
		cmp(16'(sleep), 16'h0000);
		wr(5'h11, 16'h0108);
		@(posedge i_clk) ext_low <= 1'b1;
		tick(5);
		cmp(16'(pd_req), 16'h0001);
		@(posedge i_clk) ext_low <= 1'b0;
		tick(5);
		cmp(16'(pd_req), 16'h0000);
		// mid-run reset must bring back the register defaults
		wr(5'h11, 16'h0A10);
		@(posedge i_clk) i_rst_b <= 1'b0;
		tick(2);
		cmp(16'(nib), 16'h0005);
		cmp(rdata, 16'h0000);
		@(posedge i_clk) i_rst_b <= 1'b1;
		rd(5'h11, 16'h0108);
		rd(5'h12, 16'h0000);
		end_of_test();
	end
endmodule
